// ### sel_pkg.sv
/*
  sel_pkg: shared constants and carrier types for the sideband event-enable
  and link-configuration command handler.
  assumes: an upstream parser has already checked header, checksum and channel id.
*/
package sel_pkg;

  // command and response type codes
  localparam logic [7:0] CMD_EVENT_ENABLE = 8'h08;
  localparam logic [7:0] CMD_LINK_CONFIG = 8'h09;
  localparam logic [7:0] RSP_EVENT_ENABLE = 8'h88;
  localparam logic [7:0] RSP_LINK_CONFIG = 8'h89;

  // response and reason codes
  localparam logic [15:0] RESP_COMPLETED = 16'h0000;
  localparam logic [15:0] RESP_FAILED = 16'h0001;
  localparam logic [15:0] REASON_NONE = 16'h0000;
  localparam logic [15:0] REASON_PARAM_INVALID = 16'h0002;
  localparam logic [15:0] REASON_LINK_DRIVER = 16'h0001;
  localparam logic [15:0] REASON_LINK_MEDIA = 16'h0002;
  localparam logic [15:0] REASON_LINK_PARAM = 16'h0003;
  localparam logic [15:0] REASON_LINK_POWER = 16'h0004;
  localparam logic [15:0] REASON_LINK_SPEED = 16'h0005;
  localparam logic [15:0] REASON_LINK_PHY = 16'h0006;

  // event control word fields
  localparam int EVT_LINK_CHANGE_BIT = 0;
  localparam int EVT_CONFIG_REQ_BIT = 1;
  localparam int EVT_DRIVER_BIT = 2;
  localparam logic [31:0] EVT_KEEP_MASK = 32'hFFFF_0007;
  localparam int TAG_WIDTH = 8;

  // link settings word fields
  localparam int LNK_AUTONEG_BIT = 0;
  localparam int LNK_SPEED_LSB = 1;
  localparam int LNK_SPEED_WIDTH = 4;
  localparam int LNK_HALF_BIT = 8;
  localparam int LNK_FULL_BIT = 9;
  localparam int LNK_PAUSE_OFF_BIT = 10;
  localparam int LNK_ASYM_PAUSE_BIT = 11;
  localparam int LNK_OEM_VALID_BIT = 12;
  localparam logic [31:0] LNK_RESERVED_MASK = 32'hFFFF_E0E0;
  // speeds this channel can force: 10M, 100M, 1G (bit order 10M upward)
  localparam logic [3:0] LNK_SPEED_SUPPORT = 4'h7;
  localparam logic [1:0] LNK_DUPLEX_SUPPORT = 2'h3;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] REG_EVT_ENABLE = 8'h00;
  localparam logic [7:0] REG_OWNER_TAG = 8'h04;
  localparam logic [7:0] REG_LINK_SETTINGS = 8'h08;
  localparam logic [7:0] REG_LINK_OEM = 8'h0C;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_CTRL = 8'h18;
  localparam logic [7:0] REG_LAST_RESP = 8'h1C;

  // interrupt status bits
  localparam int IRQ_EVT_DONE = 0;
  localparam int IRQ_LINK_DONE = 1;
  localparam int IRQ_LINK_FAIL = 2;
  localparam int IRQ_WIDTH = 3;

  // control register bits and reset values
  localparam int CTRL_ACCEPT_BIT = 0;
  localparam int CTRL_INIT_BIT = 1;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic CTRL_ACCEPT_RESET = 1'b1;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // parsed command payload: word0 is bytes 16..19, word1 bytes 20..23
  typedef struct packed {
    logic [7:0] code;
    logic [31:0] word0;
    logic [31:0] word1;
  } sel_cmd_t;

  typedef struct packed {
    logic [7:0] rtype;
    logic [15:0] respCode;
    logic [15:0] reason;
  } sel_rsp_t;

  // link configuration handed to the phy programming logic
  typedef struct packed {
    logic autoNeg;
    logic [3:0] speeds;
    logic halfDuplex;
    logic fullDuplex;
    logic pauseEnable;
    logic asymPause;
    logic oemValid;
    logic [31:0] oemSettings;
  } sel_link_t;

endpackage

// ### sel_link_check.sv
/*
  sel_link_check: combinational validation of a link settings word.
  assumes: caller registers the verdict; pure logic, no clock.
*/
`timescale 1ns/1ps
module sel_link_check (
  // settings word from bytes 16..19
  input wire logic [31:0] settings,
  // verdict
  output logic bad,
  output logic [15:0] reason
);

  // more than one bit set in a small field
  function automatic logic multiHot(input logic [3:0] v);
    multiHot = (v & (v - 4'h1)) != 4'h0;
  endfunction

  wire logic autoNeg = settings[sel_pkg::LNK_AUTONEG_BIT];
  wire logic [3:0] speeds = settings[sel_pkg::LNK_SPEED_LSB +: sel_pkg::LNK_SPEED_WIDTH];
  wire logic [1:0] duplex = {settings[sel_pkg::LNK_FULL_BIT], settings[sel_pkg::LNK_HALF_BIT]};
  wire logic rsvdSet = (settings & sel_pkg::LNK_RESERVED_MASK) != 32'h0000_0000;
  // forced speed must be exactly one supported speed
  wire logic speedBad = !autoNeg && (multiHot(speeds) || speeds == 4'h0 ||
                        (speeds & ~sel_pkg::LNK_SPEED_SUPPORT) != 4'h0);
  // forced duplex must be exactly one supported setting
  wire logic duplexBad = !autoNeg && (duplex == 2'h3 || duplex == 2'h0 ||
                         (duplex & ~sel_pkg::LNK_DUPLEX_SUPPORT) != 2'h0);

  // reserved bits, speed and duplex failures all give the same reason
  assign bad = rsvdSet || speedBad || duplexBad;
  assign reason = bad ? sel_pkg::REASON_PARAM_INVALID : sel_pkg::REASON_NONE;

endmodule // sel_link_check

// ### sel_cmd_handler.sv
/*
  sel_cmd_handler: executes event-enable and link-configuration commands,
  keeps the enabled notification set and owner tag, emits link settings,
  answers each command with a response, and exposes state over AXI4-Lite.
  assumes: commands arrive pre-parsed and error free; one response at a time.
*/
//
// Overview of operation
// - accept event-enable command code 0x08 and switch each standard notice
// - store the command's owner tag and present it for every later notice
// - tag is low byte of bytes 16..19, control word is bytes 20..23
// - control bit 0 enables link change, bit 1 configuration required notices
// - bit 2 enables driver change notices; 3..15 reserved; 16..31 vendor controls
// - event-enable is answered with type 0x88, no specific reason codes
// - link-configuration code 0x09 drives the link to the requested settings
// - reply to link-configuration promptly, independent of link change completion
// - link settings in bytes 16..19, vendor settings in bytes 20..23
// - bit 0 autoneg, bits 1..4 speeds; several speeds only with autoneg
// - forced unsupported or multiple speeds give failed, parameter invalid
// - bits 8,9 duplex; forced bad or both set give failed, parameter invalid
// - bit 10 set disables pause; bit 11 set enables asymmetric pause
// - bit 12 validates vendor word, else ignored; bits 13..31 must be zero
// - link-configuration always answered with type 0x89
// - link conflicts may report reason codes 0x1 to 0x6
`timescale 1ns/1ps
module sel_cmd_handler (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // command stream from the packet parser
  input wire logic cmdValid,
  input wire sel_pkg::sel_cmd_t cmdData,
  output logic cmdReady,
  // response stream to the packet builder
  output logic rspValid,
  output sel_pkg::sel_rsp_t rspData,
  input wire logic rspReady,
  // notice generator side
  output logic [31:0] eventEnable,
  output logic [7:0] eventOwnerTag,
  // link programming side
  output logic linkApply,
  output sel_pkg::sel_link_t linkCfg,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);

  typedef enum logic [0:0] {ST_IDLE, ST_RESP} sel_state_t;

  sel_state_t state_q, state_d;
  logic cmdReady_q;
  sel_pkg::sel_rsp_t rsp_q, rsp_d;
  logic [31:0] evtEnable_q, evtEnable_d;
  logic [7:0] ownerTag_q, ownerTag_d;
  logic linkApply_q;
  sel_pkg::sel_link_t linkCfg_q, linkCfg_d;
  logic [31:0] linkRaw_q;
  logic [2:0] irqStatus_q, irqMask_q;
  logic accept_q;
  logic irq_q;
  logic awHeld_q, wHeld_q, bvalid_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q;
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // byte-lane merge used for every writable register
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    laneMerge = r;
  endfunction

  // register write decode: fires once both address and data are held
  wire logic regWrite = awHeld_q && wHeld_q && !bvalid_q;
  wire logic [31:0] wMerged = laneMerge(32'h0000_0000, wData_q, wStrb_q);
  wire logic wrStatus = regWrite && awAddr_q == sel_pkg::REG_IRQ_STATUS;
  wire logic wrMask = regWrite && awAddr_q == sel_pkg::REG_IRQ_MASK;
  wire logic wrCtrl = regWrite && awAddr_q == sel_pkg::REG_CTRL;
  wire logic wrMapped = wrStatus || wrMask || wrCtrl;
  // software clear of the event set and owner tag; self-clearing strobe
  wire logic initReq = wrCtrl && wMerged[sel_pkg::CTRL_INIT_BIT];

  // command handshake and decode
  wire logic cmdTake = cmdValid && cmdReady_q;
  wire logic isEvt = cmdTake && cmdData.code == sel_pkg::CMD_EVENT_ENABLE;
  wire logic isLink = cmdTake && cmdData.code == sel_pkg::CMD_LINK_CONFIG;
  wire logic rspTaken = (state_q == ST_RESP) && rspReady;
  logic linkBad;
  logic [15:0] linkReason;

  sel_link_check u_link_check (
    .settings(cmdData.word0),
    .bad(linkBad),
    .reason(linkReason)
  );

  // next state of the command engine
  always_comb begin
    state_d = state_q;
    rsp_d = rsp_q;
    case (state_q)
      ST_IDLE: begin
        if (isEvt) begin
          state_d = ST_RESP;
          rsp_d = '{sel_pkg::RSP_EVENT_ENABLE, sel_pkg::RESP_COMPLETED, sel_pkg::REASON_NONE};
        end else if (isLink) begin
          state_d = ST_RESP;
          // always answered, failed or not
          rsp_d.rtype = sel_pkg::RSP_LINK_CONFIG;
          rsp_d.respCode = linkBad ? sel_pkg::RESP_FAILED : sel_pkg::RESP_COMPLETED;
          rsp_d.reason = linkReason;
        end
      end
      ST_RESP: begin
        if (rspTaken) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // notification set and owner tag; reserved event bits are dropped
  always_comb begin
    evtEnable_d = evtEnable_q;
    ownerTag_d = ownerTag_q;
    if (initReq) begin
      evtEnable_d = 32'h0000_0000;
      ownerTag_d = 8'h00;
    end else if (isEvt && state_q == ST_IDLE) begin
      evtEnable_d = cmdData.word1 & sel_pkg::EVT_KEEP_MASK;
      ownerTag_d = cmdData.word0[sel_pkg::TAG_WIDTH-1:0];
    end
  end

  // link settings decoded from the two command words
  always_comb begin
    linkCfg_d = linkCfg_q;
    if (isLink && !linkBad && state_q == ST_IDLE) begin
      linkCfg_d.autoNeg = cmdData.word0[sel_pkg::LNK_AUTONEG_BIT];
      linkCfg_d.speeds = cmdData.word0[sel_pkg::LNK_SPEED_LSB +: sel_pkg::LNK_SPEED_WIDTH];
      linkCfg_d.halfDuplex = cmdData.word0[sel_pkg::LNK_HALF_BIT];
      linkCfg_d.fullDuplex = cmdData.word0[sel_pkg::LNK_FULL_BIT];
      linkCfg_d.pauseEnable = !cmdData.word0[sel_pkg::LNK_PAUSE_OFF_BIT];
      linkCfg_d.asymPause = cmdData.word0[sel_pkg::LNK_ASYM_PAUSE_BIT];
      linkCfg_d.oemValid = cmdData.word0[sel_pkg::LNK_OEM_VALID_BIT];
      // vendor word kept only when flagged valid, otherwise the old one stays
      if (cmdData.word0[sel_pkg::LNK_OEM_VALID_BIT]) begin
        linkCfg_d.oemSettings = cmdData.word1;
      end
    end
  end

  // command engine registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      rsp_q <= '0;
      cmdReady_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rsp_q <= rsp_d;
      // ready only while idle and not about to leave idle
      cmdReady_q <= accept_q && state_d == ST_IDLE && !cmdTake;
    end
  end

  // configuration registers and apply strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      evtEnable_q <= 32'h0000_0000;
      ownerTag_q <= 8'h00;
      linkCfg_q <= '0;
      linkRaw_q <= 32'h0000_0000;
      linkApply_q <= 1'b0;
    end else begin
      evtEnable_q <= evtEnable_d;
      ownerTag_q <= ownerTag_d;
      linkCfg_q <= linkCfg_d;
      // the apply pulse goes out with the response; phy work may finish much later
      linkApply_q <= isLink && !linkBad && state_q == ST_IDLE;
      if (isLink && !linkBad && state_q == ST_IDLE) begin
        linkRaw_q <= cmdData.word0;
      end
    end
  end

  // interrupt status: hardware set wins over a write-one clear
  wire logic [2:0] irqSet = {isLink && linkBad, isLink, isEvt};
  wire logic [2:0] irqClr = wrStatus ? wMerged[2:0] : 3'h0;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqStatus_q <= 3'h0;
      irqMask_q <= sel_pkg::IRQ_MASK_RESET;
      accept_q <= sel_pkg::CTRL_ACCEPT_RESET;
      irq_q <= 1'b0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~irqClr) | irqSet;
      irq_q <= (((irqStatus_q & ~irqClr) | irqSet) & irqMask_q) != 3'h0;
      if (wrMask) begin
        irqMask_q <= wMerged[2:0];
      end
      if (wrCtrl) begin
        accept_q <= wMerged[sel_pkg::CTRL_ACCEPT_BIT];
      end
    end
  end

  // write channel: address and data held independently, response after both
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bresp_q <= sel_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (regWrite) begin
        bvalid_q <= 1'b1;
        bresp_q <= wrMapped ? sel_pkg::AXI_OKAY : sel_pkg::AXI_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
    end
  end

  // read decode; unmapped offsets answer zero with an error
  wire logic [7:0] rAddr = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rMux;
  logic rHit;

  always_comb begin
    rMux = 32'h0000_0000;
    rHit = 1'b1;
    case (rAddr)
      sel_pkg::REG_EVT_ENABLE: rMux = evtEnable_q;
      sel_pkg::REG_OWNER_TAG: rMux = {24'h00_0000, ownerTag_q};
      sel_pkg::REG_LINK_SETTINGS: rMux = linkRaw_q;
      sel_pkg::REG_LINK_OEM: rMux = linkCfg_q.oemSettings;
      sel_pkg::REG_IRQ_STATUS: rMux = {29'h0000_0000, irqStatus_q};
      sel_pkg::REG_IRQ_MASK: rMux = {29'h0000_0000, irqMask_q};
      sel_pkg::REG_CTRL: rMux = {31'h0000_0000, accept_q};
      sel_pkg::REG_LAST_RESP: rMux = {rsp_q.respCode, rsp_q.reason};
      default: rHit = 1'b0;
    endcase
  end

  // read channel: one outstanding read, answered the cycle after address
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= sel_pkg::AXI_OKAY;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rMux;
        rresp_q <= rHit ? sel_pkg::AXI_OKAY : sel_pkg::AXI_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // outputs, all from flops
  assign cmdReady = cmdReady_q;
  assign rspValid = state_q == ST_RESP;
  assign rspData = rsp_q;
  assign eventEnable = evtEnable_q;
  assign eventOwnerTag = ownerTag_q;
  assign linkApply = linkApply_q;
  assign linkCfg = linkCfg_q;
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;

endmodule // sel_cmd_handler

// ### sel_cmd_handler_sva.sv
/*
  sel_cmd_handler_sva: port-level checks of the command handler.
  assumes: single sys_clk domain, reset async active high.
*/
`timescale 1ns/1ps
module sel_cmd_handler_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // command and response streams
  input wire logic cmdValid,
  input wire sel_pkg::sel_cmd_t cmdData,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire sel_pkg::sel_rsp_t rspData,
  input wire logic rspReady,
  // notice and link sides
  input wire logic [31:0] eventEnable,
  input wire logic [7:0] eventOwnerTag,
  input wire logic linkApply,
  input wire sel_pkg::sel_link_t linkCfg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic evtTake;
  logic lnkTake;
  logic [31:0] w;
  // takes decoded once so every property reads the same cause
  assign w = cmdData.word0;
  assign evtTake = cmdValid && cmdReady && cmdData.code == sel_pkg::CMD_EVENT_ENABLE;
  assign lnkTake = cmdValid && cmdReady && cmdData.code == sel_pkg::CMD_LINK_CONFIG;

  a_evt_answer: assert property (evtTake |=> rspValid && rspData.rtype == sel_pkg::RSP_EVENT_ENABLE
    && rspData.respCode == sel_pkg::RESP_COMPLETED) else $error("event response wrong");
  a_evt_store: assert property (evtTake |=> eventEnable == ($past(cmdData.word1) & sel_pkg::EVT_KEEP_MASK)
    && eventOwnerTag == $past(w[7:0])) else $error("event set or tag not stored");
  a_evt_reserved: assert property ((eventEnable & ~sel_pkg::EVT_KEEP_MASK) == 32'h0000_0000)
    else $error("reserved event bits set");
  a_link_answer: assert property (lnkTake |=> rspValid && rspData.rtype == sel_pkg::RSP_LINK_CONFIG)
    else $error("link response missing");
  a_rsp_hold: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData))
    else $error("response dropped early");
  a_forced_bad: assert property (lnkTake && !w[0] && ($countones(w[4:1]) != 1 || w[4] || w[9] == w[8])
    |=> rspData.respCode == sel_pkg::RESP_FAILED && rspData.reason == sel_pkg::REASON_PARAM_INVALID)
    else $error("bad forced setting accepted");
  a_reserved_bad: assert property (lnkTake && (w & sel_pkg::LNK_RESERVED_MASK) != 32'h0000_0000
    |=> rspData.respCode == sel_pkg::RESP_FAILED) else $error("reserved link bits accepted");
  a_fail_quiet: assert property (rspValid && rspData.respCode == sel_pkg::RESP_FAILED |-> !linkApply)
    else $error("failed command applied");
  a_apply_fields: assert property (linkApply |-> linkCfg.pauseEnable == !$past(w[10])
    && linkCfg.asymPause == $past(w[11]) && linkCfg.speeds == $past(w[4:1]) && linkCfg.autoNeg == $past(w[0]))
    else $error("applied link fields wrong");
  a_oem_take: assert property (linkApply && $past(w[12]) |-> linkCfg.oemSettings == $past(cmdData.word1))
    else $error("vendor word not applied");
endmodule // sel_cmd_handler_sva

bind sel_cmd_handler sel_cmd_handler_sva chk_u (.sys_clk, .reset, .cmdValid, .cmdData, .cmdReady,
  .rspValid, .rspData, .rspReady, .eventEnable, .eventOwnerTag, .linkApply, .linkCfg);

// ### sel_mc_model.sv
/*
  sel_mc_model: behavioural management controller offering commands.
  assumes: design answers each taken command with one response.
*/
`timescale 1ns/1ps
module sel_mc_model (
  // clock
  input wire logic sys_clk,
  // command side
  output sel_pkg::sel_cmd_t cmdData,
  output logic cmdValid,
  input wire logic cmdReady,
  // response side
  input wire logic rspValid,
  input wire sel_pkg::sel_rsp_t rspData,
  output logic rspReady
);
  sel_pkg::sel_rsp_t got;
  initial begin
    cmdValid = 1'b0;
    cmdData = '0;
    rspReady = 1'b0;
  end
  // one command and its response; lag stalls rspReady to act slowly
  task automatic send(input logic [7:0] c, input logic [31:0] w0, input logic [31:0] w1, input int lag);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdData <= '{c, w0, w1};
    do @(posedge sys_clk);
    while (!cmdReady);
    cmdValid <= 1'b0;
    cmdData <= ~cmdData; // released payload must not linger
    repeat (lag) @(posedge sys_clk);
    rspReady <= 1'b1;
    do @(posedge sys_clk);
    while (!rspValid);
    got = rspData;
    rspReady <= 1'b0;
  endtask
endmodule // sel_mc_model

// ### tb_sideband_event_enable_and_link_config.sv
/*
  tb_sideband_event_enable_and_link_config: directed bench for the handler.
  assumes: sel_mc_model drives commands, tasks here drive AXI4-Lite.
*/
`timescale 1ns/1ps
module tb_sideband_event_enable_and_link_config;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, eventEnable;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cmdValid, cmdReady, rspValid, rspReady, linkApply, irq;
  logic [7:0] eventOwnerTag;
  sel_pkg::sel_cmd_t cmdData;
  sel_pkg::sel_rsp_t rspData;
  sel_pkg::sel_link_t linkCfg;
  int errors = 0, tests_run = 0, applyCount = 0;
  logic [31:0] lw [6] = '{32'h0000_1E04, 32'h0000_0206, 32'h0000_0210, 32'h0000_0304, 32'h0000_2203, 32'h0000_031F};
  logic lok [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  always #5 sys_clk = ~sys_clk;
  // count apply pulses so failed commands can be seen to leave the link alone
  always @(posedge sys_clk) if (linkApply === 1'b1) applyCount++;

  sel_cmd_handler dut_u (.sys_clk(sys_clk), .reset(reset), .cmdValid(cmdValid), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspReady(rspReady),
    .eventEnable(eventEnable), .eventOwnerTag(eventOwnerTag), .linkApply(linkApply), .linkCfg(linkCfg),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
  sel_mc_model mc_u (.sys_clk(sys_clk), .cmdData(cmdData), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspReady(rspReady));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(64'(s_axi_bresp), 64'(er));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(64'(s_axi_rdata), 64'(ed));
    chk(64'(s_axi_rresp), 64'(er));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog: whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    results();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(sel_pkg::REG_IRQ_MASK, 32'h0000_0000, sel_pkg::AXI_OKAY);
    rdc(sel_pkg::REG_CTRL, 32'h0000_0001, sel_pkg::AXI_OKAY);
    rdc(8'h20, 32'h0000_0000, sel_pkg::AXI_SLVERR);
    wrc(sel_pkg::REG_EVT_ENABLE, 32'hFFFF_FFFF, sel_pkg::AXI_SLVERR);
    rdc(sel_pkg::REG_EVT_ENABLE, 32'h0000_0000, sel_pkg::AXI_OKAY);
    $display("test registers done");
    mc_u.send(sel_pkg::CMD_EVENT_ENABLE, 32'hFFFF_FF5A, 32'hABCD_FFFF, 0);
    chk(64'(mc_u.got), 64'({sel_pkg::RSP_EVENT_ENABLE, 32'h0000_0000}));
    chk(64'(eventEnable), 64'hABCD_0007);
    chk(64'(eventOwnerTag), 64'h5A);
    mc_u.send(sel_pkg::CMD_EVENT_ENABLE, 32'h0000_0011, 32'h0000_0005, 3);
    chk(64'(eventEnable), 64'h5);
    rdc(sel_pkg::REG_OWNER_TAG, 32'h0000_0011, sel_pkg::AXI_OKAY);
    $display("test event enable done");
    for (int i = 0; i < 6; i++) begin
      mc_u.send(sel_pkg::CMD_LINK_CONFIG, lw[i], 32'hC0DE_0000 + i, i);
      chk(64'(mc_u.got), 64'({sel_pkg::RSP_LINK_CONFIG, 15'h0, !lok[i], 14'h0, !lok[i], 1'b0}));
      if (i == 0) chk(64'(linkCfg), 64'({1'b0, 4'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 32'hC0DE_0000}));
      // the failed reserved-bit command must be the one the last-response register shows
      if (i == 4) rdc(sel_pkg::REG_LAST_RESP, 32'h0001_0002, sel_pkg::AXI_OKAY);
    end
    chk(64'(applyCount), 64'h2);
    chk(64'(linkCfg), 64'({1'b1, 4'hF, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 32'hC0DE_0000}));
    rdc(sel_pkg::REG_LINK_SETTINGS, 32'h0000_031F, sel_pkg::AXI_OKAY);
    rdc(sel_pkg::REG_LINK_OEM, 32'hC0DE_0000, sel_pkg::AXI_OKAY);
    $display("test link config done");
    rdc(sel_pkg::REG_IRQ_STATUS, 32'h0000_0007, sel_pkg::AXI_OKAY);
    chk(64'(irq), 64'h0);
    wrc(sel_pkg::REG_IRQ_MASK, 32'h0000_0002, sel_pkg::AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(64'(irq), 64'h1);
    wrc(sel_pkg::REG_IRQ_STATUS, 32'h0000_0002, sel_pkg::AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(64'(irq), 64'h0);
    rdc(sel_pkg::REG_IRQ_STATUS, 32'h0000_0005, sel_pkg::AXI_OKAY);
    $display("test interrupt done");
    wrc(sel_pkg::REG_CTRL, 32'h0000_0003, sel_pkg::AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(64'(eventEnable), 64'h0);
    chk(64'(eventOwnerTag), 64'h0);
    wrc(sel_pkg::REG_CTRL, 32'h0000_0000, sel_pkg::AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(64'(cmdReady), 64'h0);
    wrc(sel_pkg::REG_CTRL, 32'h0000_0001, sel_pkg::AXI_OKAY);
    mc_u.send(sel_pkg::CMD_EVENT_ENABLE, 32'h0000_0033, 32'h0001_0002, 1);
    chk(64'(eventEnable), 64'h0001_0002);
    $display("test init and accept done");
    results();
  end
endmodule // tb_sideband_event_enable_and_link_config
